// [hdl/ref_clock_out_pin_route.sv]
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// RULE1 - software disables output before changing divider/source
// RULE2 - reference clock routed to remappable pin via selects
// RULE3 - select 8 bits 13-8 pick pin a function
// RULE4 - select 9 bits 5-0 pick pin b function
// RULE5 - unused select bits ignore writes, read zero
// RULE6 - four-bit divider: code zero undivided, powers two; on the system clock code zero toggles every cycle, same as code one
module ref_clock_out_pin_route
    import refclk_pkg::*;
#(
    parameter int NUM_FUNCS = 64    // width of the function input bus
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ce,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // clock sources and power state
    input  wire logic                 i_osc_clk,     // crystal oscillator
    input  wire logic                 i_sleep,       // device in sleep
    input  wire logic [NUM_FUNCS-1:0] i_periph_out,  // peripheral outputs
    // remappable pins
    output logic                      o_remap_pin_a,
    output logic                      o_remap_pin_a_oe,
    output logic                      o_remap_pin_b,
    output logic                      o_remap_pin_b_oe,
    output logic                      o_ref_clk      // divided clock
);

    // registers
    // all state lives in flops on i_mclk; nothing here runs on the
    // crystal clock, which is only ever sampled through synchronisers
    // so the block stays a single clock domain
    logic [15:0]  ctrl_reg;          // reference clock control
    logic [15:0]  sel8_reg;          // pin select 8
    logic [15:0]  sel9_reg;          // pin select 9
    bus_phase_t   phase_reg;         // latched address phase
    logic [DIV_CNT_W-1:0] cnt_reg;   // divider counter
    logic         ref_reg;           // divided clock output
    logic         osc_s1_reg;        // oscillator sync stage 1
    logic         osc_s2_reg;        // oscillator sync stage 2
    logic         osc_s3_reg;        // previous oscillator level
    logic         slp_s1_reg;        // sleep sync stage 1
    logic         slp_s2_reg;        // sleep sync stage 2
    logic [NUM_FUNCS-1:0] per_s1_reg; // peripheral sync stage 1
    logic [NUM_FUNCS-1:0] per_s2_reg; // peripheral sync stage 2

    // decode and selection wires
    // most decodes are named continuous assignments; the write masks and the
    // divider's tick-or-code-zero condition are applied inside the clocked processes below
    ref_ctrl_t    ctrl;
    wire          addr_take;
    wire          wr_do;
    wire          wr_ctrl;
    wire          wr_sel8;
    wire          wr_sel9;
    wire [15:0]   wdata16;
    wire [15:0]   rd_sel;
    wire          src_tick;
    wire          run_en;
    wire [DIV_CNT_W-1:0] cnt_next;
    wire          ref_next;
    wire [5:0]    func_a;
    wire [5:0]    func_b;

    // control field unpacking
    // the struct gives the divider logic readable names; bit 14 is a
    // hole in the register and never reaches any logic
    assign ctrl.enable    = ctrl_reg[BIT_ENABLE];
    assign ctrl.run_sleep = ctrl_reg[BIT_RUN_SLEEP];
    assign ctrl.source    = ctrl_reg[BIT_SOURCE];
    assign ctrl.divider   = ctrl_reg[DIV_LSB +: DIV_W];

    // bus decode: single whole-word transfers, zero wait states
    // the address phase is only taken when hready is high, which keeps
    // us in step with other slaves stretching a data phase; only the
    // low address byte is decoded, so the registers alias across the
    // slave's window and hsize is not checked
    assign addr_take = hsel & hready & htrans[1];
    assign wr_do     = phase_reg.valid & phase_reg.write;
    assign wr_ctrl   = wr_do & (phase_reg.addr == OFS_REF_CTRL);
    assign wr_sel8   = wr_do & (phase_reg.addr == OFS_PIN_SEL_8);
    assign wr_sel9   = wr_do & (phase_reg.addr == OFS_PIN_SEL_9);
    assign wdata16   = hwdata[15:0];

    // read mux; unmapped addresses read zero
    // it looks at the latched data-phase address, so the read data
    // stands for the whole data phase and shows the register as it is
    // in that cycle
    assign rd_sel =
        (phase_reg.addr == OFS_REF_CTRL)  ? ctrl_reg :
        (phase_reg.addr == OFS_PIN_SEL_8) ? sel8_reg :
        (phase_reg.addr == OFS_PIN_SEL_9) ? sel9_reg :
        RESET_VALUE;

    // never stretches a transfer and never signals an error; the bus
    // answer is therefore fixed and needs no state of its own
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = {16'h0000, rd_sel};

    // address phase capture
    // the phase is held when hready is low so a stalled transfer
    // elsewhere on the bus does not retire our own data phase early;
    // the valid flag drops on an idle phase so nothing is written twice
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phase_reg <= '0;
        end else if (i_ce && hready) begin
            phase_reg <= '{addr_take, hwrite, haddr[7:0]};
        end
    end

    // register writes; masks drop unimplemented bits (see RULE5)
    // only the low half of hwdata is used; the upper half and any
    // hole in a register are discarded here, so reads of those bits
    // come back zero without extra logic in the read path
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_reg <= RESET_VALUE;
            sel8_reg <= RESET_VALUE;
            sel9_reg <= RESET_VALUE;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                // divider/source changes expected while disabled (see RULE1)
                ctrl_reg <= wdata16 & MASK_REF_CTRL;
            end
            if (wr_sel8) begin
                sel8_reg <= wdata16 & MASK_PIN_SEL_8;   // see RULE3
            end
            if (wr_sel9) begin
                sel9_reg <= wdata16 & MASK_PIN_SEL_9;   // see RULE4
            end
        end
    end

    // synchronisers for pin-side inputs
    // the crystal level, the sleep request and the peripheral outputs
    // all come from other domains, so each passes two flops before any
    // decode; a third flop on the crystal keeps its previous level for
    // the edge detector and is fed only from the second stage
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
            slp_s1_reg <= 1'b0;
            slp_s2_reg <= 1'b0;
            per_s1_reg <= '0;
            per_s2_reg <= '0;
        end else if (i_ce) begin
            osc_s1_reg <= i_osc_clk;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
            slp_s1_reg <= i_sleep;
            slp_s2_reg <= slp_s1_reg;
            per_s1_reg <= i_periph_out;
            per_s2_reg <= per_s1_reg;
        end
    end

    // source tick: every system clock or each oscillator rising edge
    // the crystal must run below half of i_mclk for every rising edge
    // to be seen; faster crystals lose edges and divide down slower
    assign src_tick = ctrl.source ? (osc_s2_reg & ~osc_s3_reg) : 1'b1;
    // stop in sleep unless told to keep running
    // sleep is taken from the synchronised level, two cycles late
    assign run_en   = ctrl.enable & (~slp_s2_reg | ctrl.run_sleep);

    // the counter is wide enough for the largest ratio: code 15 needs
    // 2^14 ticks per half period, which fits in DIV_CNT_W bits
    // divider: output toggles when the counter wraps after 2^(code-1)
    // source ticks; code zero toggles every system clock or follows the synchronised crystal level (see RULE6)
    assign cnt_next = (ctrl.divider == '0) ? '0 :
        ((cnt_reg >= DIV_CNT_W'((1 << (ctrl.divider - 1)) - 1)) ? '0 :
         DIV_CNT_W'(cnt_reg + 1'b1));
    assign ref_next = (ctrl.divider == '0)
        ? (ctrl.source ? osc_s2_reg : ~ref_reg)
        : ((cnt_next == '0) ? ~ref_reg : ref_reg);

    // reference divider state
    // a disable clears both counter and output, so the next enable
    // starts a full low half period from zero, except code zero on the crystal, which follows its level; changing the
    // divider while enabled is left to software to avoid, as the new
    // limit may fall below the running count for one wrap
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_reg <= '0;
            ref_reg <= 1'b0;
        end else if (i_ce) begin
            if (!run_en) begin
                // held low and restarted while off
                cnt_reg <= '0;
                ref_reg <= 1'b0;
            end else if (src_tick || ctrl.divider == '0) begin
                cnt_reg <= cnt_next;                    // see RULE6
                ref_reg <= ref_next;
            end
        end
    end

    // pin function selection (see RULE2)
    // each remappable pin takes a six-bit function number from its own
    // select field; the number picks the reference clock, a released
    // pin or one synchronised peripheral output
    assign func_a = sel8_reg[PIN_A_LSB +: FUNC_W];      // see RULE3
    assign func_b = sel9_reg[PIN_B_LSB +: FUNC_W];      // see RULE4

    // pin a output slot; registered so the pin never glitches while
    // the select field or a peripheral changes
    pin_output_slot #(
        .NUM_FUNCS (NUM_FUNCS)
    ) pin_output_slot_a_i (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_func    (func_a),
        .i_ref_clk (ref_reg),
        .i_periph  (per_s2_reg),
        .o_pin     (o_remap_pin_a),     // see RULE2
        .o_pin_oe  (o_remap_pin_a_oe)
    );

    // pin b output slot; same function numbering as pin a, so the
    // reference clock may be routed to either pin or to both at once
    pin_output_slot #(
        .NUM_FUNCS (NUM_FUNCS)
    ) pin_output_slot_b_i (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_func    (func_b),
        .i_ref_clk (ref_reg),
        .i_periph  (per_s2_reg),
        .o_pin     (o_remap_pin_b),     // see RULE2
        .o_pin_oe  (o_remap_pin_b_oe)
    );

    // the divided clock is also offered directly for internal loads;
    // it leads the pins by one cycle because the pins are registered
    assign o_ref_clk = ref_reg;

endmodule // ref_clock_out_pin_route

// one remappable output pin: the function number picks what drives
// the pin, and both data and enable leave through flops so the pin
// changes only on a clock edge; function zero releases the pin
module pin_output_slot
    import refclk_pkg::*;
#(
    parameter int NUM_FUNCS = 64    // width of the function input bus
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ce,
    input  wire logic [FUNC_W-1:0]    i_func,    // selected function
    input  wire logic                 i_ref_clk, // divided reference
    input  wire logic [NUM_FUNCS-1:0] i_periph,  // synced peripherals
    output logic                      o_pin,     // pin data
    output logic                      o_pin_oe   // high while driving
);

    logic pin_reg;    // registered pin level
    logic oe_reg;     // registered pin enable
    wire  is_ref;     // function is the reference clock
    wire  pin_next;   // level the pin takes next
    wire  oe_next;    // enable the pin takes next

    // function decode; the reference clock has its own number and
    // every other nonzero number indexes the peripheral bus
    assign is_ref   = (i_func == FUNC_REF_CLK);
    assign pin_next = is_ref ? i_ref_clk : i_periph[i_func]; // see RULE2
    assign oe_next  = (i_func != FUNC_NONE);

    // pin flops; reset leaves the pin released and low
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else if (i_ce) begin
            pin_reg <= pin_next;
            oe_reg  <= oe_next;
        end
    end

    // outputs straight from the flops
    assign o_pin    = pin_reg;
    assign o_pin_oe = oe_reg;

endmodule // pin_output_slot

// [hdl/refclk_pkg.sv]
package refclk_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_REF_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PIN_SEL_8  = 8'h04;
    localparam logic [7:0] OFS_PIN_SEL_9  = 8'h08;
    localparam logic [7:0] OFS_SRC_CLK    = 8'h0C;
    // control register fields
    localparam int BIT_ENABLE    = 15;
    localparam int BIT_RUN_SLEEP = 13;
    localparam int BIT_SOURCE    = 12;
    localparam int DIV_LSB       = 8;
    localparam int DIV_W         = 4;
    // pin select fields
    localparam int FUNC_W        = 6;
    localparam int PIN_A_LSB     = 8;
    localparam int PIN_B_LSB     = 0;
    // writable masks of the 16-bit registers
    localparam logic [15:0] MASK_REF_CTRL  = 16'hBF00;
    localparam logic [15:0] MASK_PIN_SEL_8 = 16'h3F00;
    localparam logic [15:0] MASK_PIN_SEL_9 = 16'h003F;
    localparam logic [15:0] RESET_VALUE    = 16'h0000;
    // function number meaning the reference clock output
    localparam logic [5:0]  FUNC_REF_CLK   = 6'h31;
    localparam logic [5:0]  FUNC_NONE      = 6'h00;
    localparam int          DIV_CNT_W      = 15;
    // bus transfer codes
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
    localparam logic [1:0]  HTRANS_SEQ     = 2'b11;
    localparam logic        HRESP_OKAY     = 1'b0;

    // decoded control fields
    typedef struct packed {
        logic             enable;
        logic             run_sleep;
        logic             source;
        logic [DIV_W-1:0] divider;
    } ref_ctrl_t;

    // latched address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_phase_t;
endpackage

// [testbench/pin_load_model.sv]
`timescale 1ns/1ps
// package pin seen from outside; a released pin does not hold its level
module pin_load_model (
    input  wire logic i_pin,
    input  wire logic i_oe,
    output logic      o_level
);
    logic last_reg = 1'b0; // last driven level
    // remember what the device drove while it drove
    always @(i_pin or i_oe) if (i_oe) last_reg = i_pin;
    assign o_level = i_oe ? i_pin : ~last_reg;
endmodule // pin_load_model

// [testbench/ref_clock_out_pin_route_bench.sv]
`timescale 1ns/1ps
module ref_clock_out_pin_route_bench
    import refclk_pkg::*;
();
    logic        i_mclk = 0, i_rst = 1, hsel = 0, hwrite = 0, i_osc_clk = 0;
    logic        i_sleep = 0, ce = 1, pr, pra;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [63:0] i_periph_out = 0;
    logic [15:0] mdl [5]; // model registers by word index
    logic [15:0] msk [5] = '{MASK_REF_CTRL, MASK_PIN_SEL_8, MASK_PIN_SEL_9,
                            16'h0000, 16'h0000};
    wire logic   hreadyout, pa, pa_oe, pb, pb_oe, ref_clk, lvl_a, lvl_b;
    int          mismatches = 0, tests_run = 0, cnt, cnta, k, e;
    ref_clock_out_pin_route #(.NUM_FUNCS(64)) ref_clock_out_pin_route_i (
        .i_mclk, .i_rst, .i_ce(ce), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp(), .i_osc_clk, .i_sleep, .i_periph_out, .o_remap_pin_a(pa),
        .o_remap_pin_a_oe(pa_oe), .o_remap_pin_b(pb), .o_remap_pin_b_oe(pb_oe),
        .o_ref_clk(ref_clk));
    pin_load_model pin_load_model_a_i (.i_pin(pa), .i_oe(pa_oe),
        .o_level(lvl_a));
    pin_load_model pin_load_model_b_i (.i_pin(pb), .i_oe(pb_oe),
        .o_level(lvl_b));
    initial forever #2.5 i_mclk = ~i_mclk;
    initial forever #7.3 i_osc_clk = ~i_osc_clk; // free crystal
    task automatic chk(input string nm, input logic [31:0] x, g);
        tests_run++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one single transfer; the model keeps what a write leaves behind
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
        @(posedge i_mclk);
        while (hreadyout !== 1'b1) @(posedge i_mclk);
        htrans <= 2'b00; hsel <= 0; hwdata <= d;
        @(posedge i_mclk);
        while (hreadyout !== 1'b1) @(posedge i_mclk);
        rd = hrdata;
        if (w) mdl[a[4:2]] = d[15:0] & msk[a[4:2]];
    endtask
    task automatic rdchk(input logic [7:0] a);
        xfer(0, a, 0);
        chk("register", {16'h0, mdl[a[4:2]]}, rd);
    endtask
    // toggles of the reference output and of pin a over a window
    task automatic count_toggles;
        cnt = 0; cnta = 0; pr = ref_clk; pra = lvl_a;
        repeat (512) begin
            @(posedge i_mclk);
            cnt += (ref_clk != pr); cnta += (lvl_a != pra);
            pr = ref_clk; pra = lvl_a;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        print_verdict;
    end
    initial begin
        void'($urandom(2820));
        foreach (mdl[i]) mdl[i] = 16'h0000;
        repeat (20) @(posedge i_mclk);
        i_rst <= 0;
        @(posedge i_mclk);
        for (k = 0; k < 5; k++) rdchk(8'(k * 4));
        $display("reset values test done");
        repeat (12) begin
            k = $urandom_range(4, 0);
            xfer(1, 8'(k * 4), $urandom & 32'hFFFF_7FFF);
            rdchk(8'(k * 4));
        end
        $display("register test done");
        xfer(1, OFS_PIN_SEL_8, {18'h0, FUNC_REF_CLK, 8'h00});
        for (k = 0; k < 9; k++) begin
            e = mdl[0] & 16'h7FFF; // enable off, old divider kept
            xfer(1, OFS_REF_CTRL, 32'(e));
            repeat (12) @(posedge i_mclk);
            e = (k << DIV_LSB) | 32'h0000_8000;
            xfer(1, OFS_REF_CTRL, 32'(e));
            repeat (16) @(posedge i_mclk);
            count_toggles;
            e = (k == 0) ? 512 : 512 >> (k - 1);
            chk("divider", 1, (cnt >= e - 1 && cnt <= e + 1));
            chk("pin a route", 1,
                (cnta >= cnt - 1 && cnta <= cnt + 1));
        end
        i_sleep <= 1;
        repeat (8) @(posedge i_mclk);
        count_toggles;
        chk("sleep stop", 0, cnt);
        e = mdl[0] | 16'h2000; // keep running in sleep
        xfer(1, OFS_REF_CTRL, 32'(e));
        repeat (8) @(posedge i_mclk);
        count_toggles;
        chk("sleep run", 1, (cnt >= 3 && cnt <= 5));
        ce <= 0;
        count_toggles;
        chk("clock enable freeze", 0, cnt);
        ce <= 1;
        i_sleep <= 0;
        xfer(1, OFS_REF_CTRL, 32'(mdl[0] & 16'h7FFF));
        $display("divider test done");
        repeat (6) begin
            k = $urandom_range(63, 1);
            if (k == FUNC_REF_CLK) k = 1;
            xfer(1, OFS_PIN_SEL_9, 32'(k));
            i_periph_out <= {$urandom, $urandom};
            repeat (6) @(posedge i_mclk);
            chk("pin b level", i_periph_out[k], lvl_b);
            chk("pin b enable", 1, pb_oe);
        end
        xfer(1, OFS_PIN_SEL_9, 0);
        repeat (4) @(posedge i_mclk);
        chk("pin b released", 0, pb_oe);
        $display("routing test done");
        print_verdict;
    end
endmodule // ref_clock_out_pin_route_bench

// [testbench/ref_clock_out_pin_route_monitor.sv]
`timescale 1ns/1ps
module ref_clock_out_pin_route_monitor
    import refclk_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        o_remap_pin_a_oe,
    input wire logic        o_remap_pin_b_oe,
    input wire logic        o_ref_clk
);
    logic       dp_reg; // data phase under way
    logic       dw_reg; // data phase is a write
    logic [7:0] da_reg; // data phase offset
    // follow each taken address phase into its data phase
    always_ff @(posedge i_mclk) begin
        if (i_rst) dp_reg <= 1'b0;
        else if (hready) dp_reg <= hsel & htrans[1] & i_ce;
        if (hready) da_reg <= haddr[7:0];
        if (hready) dw_reg <= hwrite;
    end
    wire rd8 = dp_reg & !dw_reg & (da_reg == OFS_PIN_SEL_8);
    wire rd9 = dp_reg & !dw_reg & (da_reg == OFS_PIN_SEL_9);
    wire wa  = dp_reg & dw_reg & (da_reg == OFS_PIN_SEL_8);
    wire wb  = dp_reg & dw_reg & (da_reg == OFS_PIN_SEL_9);
    wire wc  = dp_reg & dw_reg & (da_reg == OFS_REF_CTRL);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_sel8_unused;
        rd8 |-> (hrdata & ~{16'h0000, MASK_PIN_SEL_8}) == 32'h0;
    endproperty
    a_sel8_unused: assert property (p_sel8_unused)
        else $error("select 8 unused bits read nonzero");
    property p_sel9_unused;
        rd9 |-> (hrdata & ~{16'h0000, MASK_PIN_SEL_9}) == 32'h0;
    endproperty
    a_sel9_unused: assert property (p_sel9_unused)
        else $error("select 9 unused bits read nonzero");
    property p_pin_a;
        wa |-> ##2 o_remap_pin_a_oe == ($past(hwdata[13:8], 2) != 6'h00);
    endproperty
    a_pin_a: assert property (p_pin_a)
        else $error("pin a enable does not follow its function");
    property p_pin_b;
        wb |-> ##2 o_remap_pin_b_oe == ($past(hwdata[5:0], 2) != 6'h00);
    endproperty
    a_pin_b: assert property (p_pin_b)
        else $error("pin b enable does not follow its function");
    property p_ref_off;
        wc && !hwdata[15] |-> ##[1:4] !o_ref_clk [*8];
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("reference clock runs while disabled");
endmodule // ref_clock_out_pin_route_monitor
bind ref_clock_out_pin_route ref_clock_out_pin_route_monitor
    ref_clock_out_pin_route_monitor_i (.i_mclk, .i_rst, .i_ce, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hrdata, .o_remap_pin_a_oe,
    .o_remap_pin_b_oe, .o_ref_clk);
